/* eac_nv_access.sv */
`timescale 1ns/1ps
module eac_nv_access
  import eac_pkg::*;
#(
  parameter int ProgRcCycles = PROG_RC_CYCLES,
  parameter int RcDiv = RC_DIV
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // I/O register port
  input eac_io_req_s ioReq,
  output logic [7:0] ioRdData,
  // core side
  input wire logic globalIntFlag,
  input wire logic selfProgramActive,
  output logic readyIrq,
  output logic cpuStall,
  output logic programBusy
);

  // ********************************
  // storage and state
  // ********************************
  logic [7:0] nvArray [0:1023];
  eac_state_e state_q;
  eac_state_e state_d;
  logic [9:0] nvByteAddress_q;
  logic [7:0] nvByteValue_q;
  logic [1:0] programActionSelect_q;
  logic readyIrqEnable_q;
  logic writeArm_q;
  logic [2:0] armCnt_q;
  logic [2:0] stallCnt_q;
  logic [2:0] stallCnt_d;
  logic [15:0] rcDivCnt_q;
  logic [15:0] progCnt_q;
  logic [9:0] progAddr_q;
  logic [7:0] progData_q;
  logic [1:0] progMode_q;
  logic [7:0] ioRdData_q;
  logic readyIrq_q;
  logic cpuStall_q;

  // ********************************
  // decode
  // ********************************
  wire busy = (state_q == ST_PROGRAM);
  wire ctrlWr = ioReq.we && (ioReq.addr == CTRL_OFS);
  wire dataWr = ioReq.we && (ioReq.addr == DATA_OFS);
  wire addrLoWr = ioReq.we && (ioReq.addr == ADDR_LO_OFS) && !busy;
  wire addrHiWr = ioReq.we && (ioReq.addr == ADDR_HI_OFS) && !busy;
  wire armSet = ctrlWr && ioReq.wdata[ARM_BIT] && !ioReq.wdata[STROBE_BIT];
  wire strobeSet = ctrlWr && ioReq.wdata[STROBE_BIT];
  // the flash interlock is checked here too, as software may skip its own poll
  wire progStart = strobeSet && writeArm_q && !busy && !selfProgramActive;
  wire readStart = ctrlWr && ioReq.wdata[READ_BIT] && !busy;
  wire rcTick = (rcDivCnt_q == 16'(RcDiv - 1));
  wire progDone = busy && rcTick && (progCnt_q == 16'(ProgRcCycles - 1));
  wire [7:0] ctrlView = {2'h0, programActionSelect_q, readyIrqEnable_q, writeArm_q, busy, 1'b0};

  function automatic logic [7:0] apply_action(input logic [1:0] mode, input logic [7:0] old,
                                              input logic [7:0] src);
    case (mode)
      MODE_ATOMIC: apply_action = src;
      MODE_ERASE: apply_action = ERASED_BYTE;
      MODE_WRITE: apply_action = old & src;
      default: apply_action = old;
    endcase
  endfunction : apply_action

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: if (progStart) state_d = ST_PROGRAM;
      ST_PROGRAM: if (progDone) state_d = ST_IDLE;
      default: state_d = ST_IDLE;
    endcase
  end

  always_comb begin
    stallCnt_d = (stallCnt_q != 3'h0) ? stallCnt_q - 3'h1 : 3'h0;
    if (readStart) begin
      stallCnt_d = READ_STALL_CYCLES;
    end else if (progStart) begin
      stallCnt_d = WRITE_STALL_CYCLES;
    end
  end

  // ********************************
  // control register and arm timeout
  // ********************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      readyIrqEnable_q <= 1'b0;
      programActionSelect_q <= MODE_ATOMIC;
      writeArm_q <= 1'b0;
      armCnt_q <= 3'h0;
    end else begin
      state_q <= state_d;
      if (ctrlWr) begin
        readyIrqEnable_q <= ioReq.wdata[IRQ_EN_BIT];
      end
      if (ctrlWr && !busy) begin
        programActionSelect_q <= ioReq.wdata[MODE_HI_BIT:MODE_LO_BIT];
      end
      if (armSet) begin
        writeArm_q <= 1'b1;
        armCnt_q <= ARM_CYCLES;
      end else if (progStart || armCnt_q == 3'h1) begin
        writeArm_q <= 1'b0;
        armCnt_q <= 3'h0;
      end else if (armCnt_q != 3'h0) begin
        armCnt_q <= armCnt_q - 3'h1;
      end
    end
  end

  // ********************************
  // address and data registers
  // ********************************
  // address is left unreset on purpose: software must load it before use
  always_ff @(posedge ref_clk) begin
    if (addrLoWr) begin
      nvByteAddress_q[7:0] <= ioReq.wdata;
    end
    if (addrHiWr) begin
      nvByteAddress_q[9:8] <= ioReq.wdata[1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      nvByteValue_q <= DATA_RESET;
    end else if (readStart) begin
      nvByteValue_q <= nvArray[nvByteAddress_q];
    end else if (dataWr) begin
      nvByteValue_q <= ioReq.wdata;
    end
  end

  // ********************************
  // programming timer
  // ********************************
  // the RC oscillator is modelled as an enable divided from the reference clock;
  // it restarts with each write so the span is a whole number of oscillator periods
  always_ff @(posedge ref_clk) begin
    if (rst || rcTick || progStart) begin
      rcDivCnt_q <= 16'h0000;
    end else begin
      rcDivCnt_q <= rcDivCnt_q + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst || progStart) begin
      progCnt_q <= 16'h0000;
    end else if (busy && rcTick) begin
      progCnt_q <= progCnt_q + 16'h0001;
    end
  end

  // latch the operands so a later data write cannot alter a running program
  always_ff @(posedge ref_clk) begin
    if (progStart) begin
      progAddr_q <= nvByteAddress_q;
      progData_q <= nvByteValue_q;
      progMode_q <= programActionSelect_q;
    end
  end

  // array has no reset so contents survive it
  always_ff @(posedge ref_clk) begin
    if (progDone && !rst) begin
      nvArray[progAddr_q] <= apply_action(progMode_q, nvArray[progAddr_q],
                                          progData_q);
    end
  end

  // ********************************
  // outputs
  // ********************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ioRdData_q <= 8'h00;
      readyIrq_q <= 1'b0;
      cpuStall_q <= 1'b0;
      stallCnt_q <= 3'h0;
    end else begin
      // interrupt is a level, not a pulse
      readyIrq_q <= readyIrqEnable_q && globalIntFlag && (state_d == ST_IDLE)
                    && !selfProgramActive;
      stallCnt_q <= stallCnt_d;
      cpuStall_q <= (stallCnt_d != 3'h0);
      if (ioReq.re) begin
        case (ioReq.addr)
          CTRL_OFS: ioRdData_q <= ctrlView;
          DATA_OFS: ioRdData_q <= nvByteValue_q;
          ADDR_LO_OFS: ioRdData_q <= nvByteAddress_q[7:0];
          ADDR_HI_OFS: ioRdData_q <= {6'h00, nvByteAddress_q[9:8]};
          default: ioRdData_q <= 8'h00;
        endcase
      end
    end
  end

  assign ioRdData = ioRdData_q;
  assign readyIrq = readyIrq_q;
  assign cpuStall = cpuStall_q;
  assign programBusy = busy;

  // ********************************
  // checks
  // ********************************
  a_arm_held: assert property (@(posedge ref_clk) disable iff (rst)
    armSet ##1 (!progStart) [*3] |=> writeArm_q)
    else $error("write arm cleared before four cycles");

  a_arm_timeout: assert property (@(posedge ref_clk) disable iff (rst)
    armSet ##1 (!armSet) [*4] |=> !writeArm_q)
    else $error("write arm did not time out after four cycles");

  a_no_unarmed_prog: assert property (@(posedge ref_clk) disable iff (rst)
    (strobeSet && !writeArm_q && !busy) |=> !busy)
    else $error("programming started without arm");

  a_no_flash_overlap: assert property (@(posedge ref_clk) disable iff (rst)
    (!busy && selfProgramActive) |=> !busy)
    else $error("programming started during flash self-programming");

  a_armed_start: assert property (@(posedge ref_clk) disable iff (rst)
    (strobeSet && writeArm_q && !busy && !selfProgramActive)
    |=> busy && progAddr_q == $past(nvByteAddress_q))
    else $error("armed strobe did not start programming");

  a_irq_gating: assert property (@(posedge ref_clk) disable iff (rst)
    readyIrq |-> $past(readyIrqEnable_q) && $past(globalIntFlag))
    else $error("ready interrupt without enable and global flag");

  a_irq_suppress: assert property (@(posedge ref_clk) disable iff (rst)
    (busy || $past(selfProgramActive)) |-> !readyIrq)
    else $error("ready interrupt during programming");

  a_irq_level: assert property (@(posedge ref_clk) disable iff (rst)
    (readyIrq && readyIrqEnable_q && globalIntFlag && !busy && !selfProgramActive
     && !progStart) |=> readyIrq)
    else $error("ready interrupt dropped while conditions held");

  a_write_stall: assert property (@(posedge ref_clk) disable iff (rst)
    (progStart && !readStart) |=> cpuStall [*2] ##1 (!cpuStall || $past(readStart)))
    else $error("write strobe stall not two cycles");

  a_read_stall: assert property (@(posedge ref_clk) disable iff (rst)
    readStart |=> cpuStall [*4])
    else $error("read stall shorter than four cycles");

  a_busy_frozen: assert property (@(posedge ref_clk) disable iff (rst)
    busy |=> $stable(nvByteAddress_q) && $stable(programActionSelect_q))
    else $error("address or mode changed while programming");

  a_prog_length: assert property (@(posedge ref_clk) disable iff (rst)
    (busy && !progDone) |=> busy)
    else $error("busy flag dropped before programming time elapsed");

  a_busy_end: assert property (@(posedge ref_clk) disable iff (rst)
    progDone |=> !busy)
    else $error("busy flag held after programming time elapsed");

  a_operands_held: assert property (@(posedge ref_clk) disable iff (rst)
    progStart |=> progData_q == $past(nvByteValue_q)
    && progMode_q == $past(programActionSelect_q))
    else $error("programming operands not taken at the strobe");

  a_irq_disable: assert property (@(posedge ref_clk) disable iff (rst)
    (ctrlWr && !ioReq.wdata[IRQ_EN_BIT]) |-> ##2 !readyIrq)
    else $error("ready interrupt still requested after disable");

  a_irq_resume: assert property (@(posedge ref_clk) disable iff (rst)
    (progDone && readyIrqEnable_q && globalIntFlag && !selfProgramActive) |=> readyIrq)
    else $error("ready interrupt not raised when programming ended");

  a_read_loads: assert property (@(posedge ref_clk) disable iff (rst)
    readStart |=> nvByteValue_q == $past(nvArray[nvByteAddress_q]))
    else $error("read strobe did not load the addressed byte");

  a_read_blocked: assert property (@(posedge ref_clk) disable iff (rst)
    (busy && ctrlWr) |=> $stable(nvByteValue_q) && !$rose(cpuStall))
    else $error("read strobe acted while programming");

  a_stall_quiet: assert property (@(posedge ref_clk) disable iff (rst)
    (stallCnt_q == 3'h0 && !readStart && !progStart) |=> !cpuStall)
    else $error("stall raised without a strobe");

  a_addr_load: assert property (@(posedge ref_clk) disable iff (rst)
    addrLoWr |=> nvByteAddress_q[7:0] == $past(ioReq.wdata))
    else $error("address low byte not loaded");

  a_data_load: assert property (@(posedge ref_clk) disable iff (rst)
    dataWr |=> nvByteValue_q == $past(ioReq.wdata))
    else $error("data register not loaded");

  a_erase_value: assert property (@(posedge ref_clk) disable iff (rst)
    (progDone && progMode_q == MODE_ERASE) |=> nvArray[$past(progAddr_q)] == ERASED_BYTE)
    else $error("erase did not leave the erased value");

  a_atomic_value: assert property (@(posedge ref_clk) disable iff (rst)
    (progDone && progMode_q == MODE_ATOMIC) |=> nvArray[$past(progAddr_q)] == $past(progData_q))
    else $error("atomic write did not store the data byte");

endmodule : eac_nv_access

/* eac_pkg.sv */
// Contract
// - ready interrupt requested only with its enable bit and global interrupt flag set
// - ready interrupt is a steady level while write strobe reads zero and enabled
// - ready interrupt suppressed during EEPROM programming or flash self-programming
// - programming starts at current address and data only if strobe set while armed
// - write strobe with write-arm zero performs no programming
// - write-arm clears itself four clock cycles after software sets it
// - no EEPROM programming while flash self-programming is active
// - write strobe flag stays one through programming, hardware clears it when done
// - setting write strobe stalls the CPU for two cycles
// - read strobe loads the addressed byte into the data register at once
// - a read stalls the CPU for four cycles
// - while programming, read strobes are ignored and address writes blocked
// - programming lasts 26,368 calibrated oscillator cycles, typically 3.3 ms
// - mode 00 erase+write, 01 erase, 10 write, 11 reserved; frozen while busy
// - 10-bit linear byte address 0..1023, undefined after reset
// - data register is write source and read destination
package eac_pkg;

  // ********************************
  // register map (data-space offsets)
  // ********************************
  localparam logic [7:0] CTRL_OFS = 8'h3F;
  localparam logic [7:0] DATA_OFS = 8'h40;
  localparam logic [7:0] ADDR_LO_OFS = 8'h41;
  localparam logic [7:0] ADDR_HI_OFS = 8'h42;

  // control register fields
  localparam int READ_BIT = 0;
  localparam int STROBE_BIT = 1;
  localparam int ARM_BIT = 2;
  localparam int IRQ_EN_BIT = 3;
  localparam int MODE_LO_BIT = 4;
  localparam int MODE_HI_BIT = 5;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ********************************
  // programming actions
  // ********************************
  localparam logic [1:0] MODE_ATOMIC = 2'h0;
  localparam logic [1:0] MODE_ERASE = 2'h1;
  localparam logic [1:0] MODE_WRITE = 2'h2;

  // ********************************
  // timing
  // ********************************
  localparam logic [2:0] ARM_CYCLES = 3'h4;
  localparam logic [2:0] WRITE_STALL_CYCLES = 3'h2;
  localparam logic [2:0] READ_STALL_CYCLES = 3'h4;
  localparam int REF_CLK_KHZ = 40000;
  localparam int RC_OSC_KHZ = 8000;
  localparam int RC_DIV = REF_CLK_KHZ / RC_OSC_KHZ;
  localparam int PROG_RC_CYCLES = 26368;
  localparam int PROG_TIME_US = 3300;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_PROGRAM = 1'b1
  } eac_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } eac_io_req_s;

endpackage : eac_pkg

/* eac_flash_model.sv */
`timescale 1ns/1ps
module eac_flash_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // control
  input wire logic start,
  output logic selfProgramActive
);
  logic [3:0] cnt_q;
  // ********************************
  // flash self-programming span
  // ********************************
  // fixed span keeps the overlap with an eeprom write predictable
  always_ff @(posedge ref_clk) begin
    if (rst) cnt_q <= 4'h0;
    else if (start) cnt_q <= 4'hF;
    else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
  end
  assign selfProgramActive = (cnt_q != 4'h0);
endmodule : eac_flash_model

/* eac_nv_access_tb.sv */
`timescale 1ns/1ps
module eac_nv_access_tb import eac_pkg::*;;
  localparam int PRC = 16;
  localparam int RDV = 2;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  eac_io_req_s ioReq = '0;
  logic globalIntFlag = 1'b0;
  logic fStart = 1'b0;
  logic selfProgramActive, readyIrq, cpuStall, programBusy;
  logic [7:0] ioRdData;
  int n_fail = 0;
  int n_compared = 0;
  int seed = 32'h4dd7;
  int cyc = 0;
  int mem[int];
  logic [9:0] a;
  logic [1:0] mods[4] = '{2'h0, 2'h2, 2'h1, 2'h3};
  eac_nv_access #(.ProgRcCycles(PRC), .RcDiv(RDV)) uut (.ref_clk(ref_clk), .rst(rst),
    .ioReq(ioReq), .ioRdData(ioRdData), .globalIntFlag(globalIntFlag),
    .selfProgramActive(selfProgramActive), .readyIrq(readyIrq), .cpuStall(cpuStall),
    .programBusy(programBusy));
  eac_flash_model fsp (.ref_clk(ref_clk), .rst(rst), .start(fStart),
    .selfProgramActive(selfProgramActive));
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc++;
  // ********************************
  // bus and compare helpers
  // ********************************
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bus(input logic [7:0] ad, input logic [7:0] d, input logic r);
    @(posedge ref_clk);
    #1 ioReq = '{addr: ad, wdata: d, we: !r, re: r};
    @(posedge ref_clk);
    #1 ioReq = '0;
  endtask : bus
  task automatic stalls(input int n);
    int k;
    k = 0;
    repeat (5) begin
      if (cpuStall === 1'b1) k++;
      @(posedge ref_clk);
      #1;
    end
    chk(k[7:0], n[7:0]);
  endtask : stalls
  task automatic prog(input logic [9:0] ad, input logic [7:0] d, input logic [1:0] m,
                      input int gap, input logic ok);
    int t0;
    globalIntFlag = 1'b0;
    bus(ADDR_LO_OFS, ad[7:0], 1'b0);
    bus(ADDR_HI_OFS, {6'h00, ad[9:8]}, 1'b0);
    bus(DATA_OFS, d, 1'b0);
    bus(CTRL_OFS, {2'h0, m, 4'hC}, 1'b0);
    repeat (gap) @(posedge ref_clk);
    bus(CTRL_OFS, {2'h0, m, 4'hA}, 1'b0);
    t0 = cyc;
    chk(programBusy, ok);
    if (ok) begin
      globalIntFlag = 1'b1;
      stalls(2);
      chk(readyIrq, 8'h00);
      bus(ADDR_LO_OFS, ~ad[7:0], 1'b0);
      bus(CTRL_OFS, {2'h0, ~m, 4'h9}, 1'b0);
      stalls(0);
      bus(CTRL_OFS, 8'h00, 1'b1);
      chk(ioRdData, {2'h0, m, 4'hA});
      while (programBusy === 1'b1 && cyc - t0 < PRC * RDV + 40) begin
        @(posedge ref_clk);
        #1;
      end
      chk(8'(cyc - t0), 8'(PRC * RDV));
      chk(programBusy, 1'b0);
      mem[ad] = m == 2'h0 ? d : m == 2'h1 ? 8'hFF : m == 2'h2 ? mem[ad] & d : mem[ad];
      repeat (2) @(posedge ref_clk);
      #1 chk(readyIrq, 1'b1);
    end
    globalIntFlag = 1'b0;
    bus(CTRL_OFS, 8'h00, 1'b1);
    chk(ioRdData[STROBE_BIT], 1'b0);
    bus(CTRL_OFS, 8'h09, 1'b0);
    stalls(4);
    bus(DATA_OFS, 8'h00, 1'b1);
    chk(ioRdData, mem[ad][7:0]);
  endtask : prog
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  // ********************************
  // scenarios
  // ********************************
  initial begin
    repeat (10) @(posedge ref_clk);
    #1 rst = 1'b0;
    bus(CTRL_OFS, 8'h00, 1'b1);
    chk(ioRdData, 8'h00);
    bus(DATA_OFS, 8'h00, 1'b1);
    chk(ioRdData, DATA_RESET);
    bus(8'h55, 8'h00, 1'b1);
    chk(ioRdData, 8'h00);
    $display("reset test done");
    a = $random(seed);
    foreach (mods[i]) prog(a, $random(seed), mods[i], 0, 1'b1);
    prog(10'h3FF, $random(seed), 2'h0, 2, 1'b1);
    prog(a, $random(seed), 2'h0, 3, 1'b0);
    $display("arm test done");
    @(posedge ref_clk);
    #1 fStart = 1'b1;
    @(posedge ref_clk);
    #1 fStart = 1'b0;
    prog(10'h3FF, $random(seed), 2'h0, 0, 1'b0);
    globalIntFlag = $random(seed);
    repeat (3) @(posedge ref_clk);
    #1 chk(readyIrq, globalIntFlag);
    bus(CTRL_OFS, 8'h00, 1'b0);
    globalIntFlag = 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 chk(readyIrq, 1'b0);
    $display("flash and irq test done");
    stop_test();
  end
  initial begin
    #(25 * 20000);
    n_fail++;
    stop_test();
  end
endmodule : eac_nv_access_tb
